// file: hdl/bus_timeout.sv
/*
  Bus inactivity watcher: counts idle cycles while the device is addressed
  and pulses a release once the limit is passed.
  Assumes activity and addressed come from logic on the same clock.
*/
module bus_timeout
  import lock_cfg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Control and bus observation.
  input  wire logic enable_in,
  input  wire logic addressed_in,
  input  wire logic activity_in,
  // Release request.
  output logic      release_out
);

  localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 2) begin : g_check
    $error("bus_timeout needs a limit of at least two cycles");
  end

  timeout_state_t   state_q;
  timeout_state_t   state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             expired;

  assign expired = (count_q == CNT_W'(TIMEOUT_CYCLES));

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      TO_IDLE: begin
        count_d = '0;
        if (enable_in && addressed_in) begin
          state_d = TO_WATCH;
        end
      end
      TO_WATCH: begin
        // Without the enable the bus is never released on idleness.
        if (!enable_in || !addressed_in) begin  // see RULE_10
          state_d = TO_IDLE;
          count_d = '0;
        end else if (activity_in) begin
          count_d = '0;
        end else if (expired) begin  // see RULE_06
          state_d = TO_RELEASED;
        end else begin
          count_d = count_q + CNT_W'(1);
        end
      end
      TO_RELEASED: begin
        count_d = '0;
        if (!addressed_in) begin
          state_d = TO_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q     <= TO_IDLE;
      count_q     <= '0;
      release_out <= 1'b0;
    end else begin
      state_q     <= state_d;
      count_q     <= count_d;
      release_out <= (state_q == TO_WATCH) && (state_d == TO_RELEASED);
    end
  end

endmodule

// file: hdl/lock_cfg_pkg.sv
/*
  Shared constants for the lock/reset and vendor configuration registers:
  command codes, field positions, reset values and the bus timeout figure.
  Assumes a 25 MHz device clock; every hdl module imports the whole package.
*/
package lock_cfg_pkg;

  // Clock rate and the bus inactivity limit in its own unit.
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned BUS_TIMEOUT_MS  = 35;
  // A least time; CLK_HZ / 1000 truncates, exact at 25 MHz; 35 ms is 875000 cycles.
  localparam int unsigned BUS_TIMEOUT_CYC =
    (BUS_TIMEOUT_MS * (CLK_HZ / 1000) + 0) > 0 ?
    BUS_TIMEOUT_MS * (CLK_HZ / 1000) : 1;

  // Command codes of the two registers.
  localparam logic [7:0] CMD_LOCK_AND_SOFT_RESET  = 8'hd0;
  localparam logic [7:0] CMD_VENDOR_CONFIGURATION = 8'hd1;

  // Reset values.
  localparam logic [7:0] LOCK_RESET_VALUE = 8'h00;
  localparam logic [7:0] CFG_RESET_VALUE  = 8'h07;

  // Field positions of the lock and soft reset register.
  localparam int unsigned LOCK_BIT       = 0;
  localparam int unsigned SOFT_RESET_BIT = 1;

  // Field positions of the vendor configuration register.
  localparam int unsigned PS_SEL_MSB         = 7;
  localparam int unsigned PS_SEL_LSB         = 6;
  localparam int unsigned RSVD_MSB           = 5;
  localparam int unsigned RSVD_LSB           = 4;
  localparam int unsigned TIMEOUT_EN_BIT     = 3;
  localparam int unsigned FAULT_EN_BIT       = 2;
  localparam int unsigned ALERT_EN_BIT       = 1;
  localparam int unsigned MONITOR_EN_BIT     = 0;

  // Power save phase codes and the phase counts they select.
  localparam logic [1:0] PS_SEL_TWO_PHASE = 2'h1;
  localparam logic [1:0] PHASES_ONE       = 2'h1;
  localparam logic [1:0] PHASES_TWO       = 2'h2;

  // Timeout watcher states, Gray coded along idle, watch, released.
  typedef enum logic [1:0] {
    TO_IDLE     = 2'h0,
    TO_WATCH    = 2'h1,
    TO_RELEASED = 2'h3
  } timeout_state_t;

endpackage

// file: hdl/pin_sync.sv
/*
  Three stage synchroniser for a group of pin inputs with change detect.
  Assumes the pins are asynchronous to the device clock.
*/
module pin_sync
  import lock_cfg_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Pins and their settled values.
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] level_out,
  output logic                  changed_out
);

  if (WIDTH < 1) begin : g_check
    $error("pin_sync needs at least one pin");
  end

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  // A pin counts as changed only once the two later stages agree.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_out[i];
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q        <= '1;
      s2_q        <= '1;
      s3_q        <= '1;
      level_out   <= '1;
      changed_out <= 1'b0;
    end else begin
      s1_q        <= pins_in;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      level_out   <= level_d;
      changed_out <= |(level_d ^ level_out);
    end
  end

endmodule

// file: hdl/pmbus_lock_and_config_regs.sv
/*
  Lock/soft reset and vendor configuration registers behind the command
  port of a bus protocol engine, with the pin gates they steer.
  Assumes the protocol engine decodes transactions into one-cycle command
  strobes and reports when the device is addressed; the bus pins are only
  watched here for the inactivity timeout.
*/
// Functional notes
// RULE_01 - A soft reset write returns every register to its default.
// RULE_02 - While locked, a soft reset write is ignored.
// RULE_03 - A lock write freezes the limits, and the lock cannot be cleared.
// RULE_04 - Once locked, lockable fields are read-only until power cycles.
// RULE_05 - Bits 7:6 give two power save phases for 01, else one; default 00.
// RULE_06 - Over 35 ms idle while addressed releases the bus if enabled.
// RULE_07 - Bit 2 gates the fault pin and is one after reset.
// RULE_08 - Bit 1 gates the alert pin, never driven while the bit is clear.
// RULE_09 - Bit 0 starts voltage monitoring, idle while it is clear.
// RULE_10 - Timeout off never releases the bus; bits 5:4 read zero.
module pmbus_lock_and_config_regs
  import lock_cfg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Command port from the protocol engine.
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_write_in,
  input  wire logic [7:0] cmd_code_in,
  input  wire logic [7:0] cmd_wdata_in,
  output logic            cmd_ack_out,
  output logic            cmd_error_out,
  output logic      [7:0] cmd_rdata_out,
  // Bus pins and transaction state.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       addressed_in,
  output logic            bus_release_out,
  // Fault and alert pins.
  input  wire logic       fault_req_in,
  input  wire logic       alert_req_in,
  output logic            fault_out,
  output logic            alert_oe_n_out,
  // Settings for the rest of the device.
  output logic      [1:0] power_save_phase_select_out,
  output logic      [1:0] power_save_phases_out,
  output logic            bus_timeout_enable_out,
  output logic            monitor_enable_out,
  output logic            lock_out,
  output logic            soft_reset_out
);

  if (TIMEOUT_CYCLES < 2) begin : g_check
    $error("bus timeout limit too short");
  end

  logic       lock_q;
  logic       lock_d;
  logic [1:0] ps_sel_q;
  logic [1:0] ps_sel_d;
  logic       timeout_en_q;
  logic       timeout_en_d;
  logic       fault_en_q;
  logic       fault_en_d;
  logic       alert_en_q;
  logic       alert_en_d;
  logic       monitor_en_q;
  logic       monitor_en_d;
  logic [7:0] rdata_d;

  // Address decode.
  wire hit_lock = cmd_valid_in && (cmd_code_in == CMD_LOCK_AND_SOFT_RESET);
  wire hit_cfg  = cmd_valid_in && (cmd_code_in == CMD_VENDOR_CONFIGURATION);
  wire hit_none = cmd_valid_in && !hit_lock && !hit_cfg;
  wire wr_lock  = hit_lock && cmd_write_in;
  wire wr_cfg   = hit_cfg && cmd_write_in;

  // Soft reset only acts while unlocked.
  wire soft_reset_req = wr_lock && cmd_wdata_in[SOFT_RESET_BIT]
                        && !lock_q;  // see RULE_01, see RULE_02
  // Soft reset wins over a lock set in the same write, so the part comes
  // back fully open rather than locked at default limits.
  wire lock_set = wr_lock && cmd_wdata_in[LOCK_BIT] && !lock_q
                  && !soft_reset_req;  // see RULE_03

  // Lock is sticky; only power-on reset clears it.
  assign lock_d = lock_q || lock_set;  // see RULE_03

  // Configuration write; the timeout enable is the lockable field.
  assign ps_sel_d     = wr_cfg ? cmd_wdata_in[PS_SEL_MSB:PS_SEL_LSB]
                               : ps_sel_q;
  assign timeout_en_d = (wr_cfg && !lock_q)
                        ? cmd_wdata_in[TIMEOUT_EN_BIT]
                        : timeout_en_q;  // see RULE_04, see RULE_06
  assign fault_en_d   = wr_cfg ? cmd_wdata_in[FAULT_EN_BIT] : fault_en_q;
  assign alert_en_d   = wr_cfg ? cmd_wdata_in[ALERT_EN_BIT] : alert_en_q;
  assign monitor_en_d = wr_cfg ? cmd_wdata_in[MONITOR_EN_BIT]
                               : monitor_en_q;

  // Read mux; the soft reset bit and reserved bits read as zero.
  wire [7:0] lock_rd = {7'h00, lock_q};
  wire [7:0] cfg_rd  = {ps_sel_q, 2'h0, timeout_en_q, fault_en_q,
                        alert_en_q, monitor_en_q};  // see RULE_10
  assign rdata_d = (hit_lock && !cmd_write_in) ? lock_rd :
                   (hit_cfg && !cmd_write_in)  ? cfg_rd  : cmd_rdata_out;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= LOCK_RESET_VALUE[LOCK_BIT];
    end else begin
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ps_sel_q     <= CFG_RESET_VALUE[PS_SEL_MSB:PS_SEL_LSB];
      timeout_en_q <= CFG_RESET_VALUE[TIMEOUT_EN_BIT];
      fault_en_q   <= CFG_RESET_VALUE[FAULT_EN_BIT];  // see RULE_07
      alert_en_q   <= CFG_RESET_VALUE[ALERT_EN_BIT];
      monitor_en_q <= CFG_RESET_VALUE[MONITOR_EN_BIT];
    end else if (soft_reset_req) begin  // see RULE_01
      ps_sel_q     <= CFG_RESET_VALUE[PS_SEL_MSB:PS_SEL_LSB];
      timeout_en_q <= CFG_RESET_VALUE[TIMEOUT_EN_BIT];
      fault_en_q   <= CFG_RESET_VALUE[FAULT_EN_BIT];
      alert_en_q   <= CFG_RESET_VALUE[ALERT_EN_BIT];
      monitor_en_q <= CFG_RESET_VALUE[MONITOR_EN_BIT];
    end else begin
      ps_sel_q     <= ps_sel_d;
      timeout_en_q <= timeout_en_d;
      fault_en_q   <= fault_en_d;
      alert_en_q   <= alert_en_d;
      monitor_en_q <= monitor_en_d;
    end
  end

  // Command answers, one cycle after the strobe.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_ack_out    <= 1'b0;
      cmd_error_out  <= 1'b0;
      cmd_rdata_out  <= 8'h00;
      soft_reset_out <= 1'b0;
    end else begin
      cmd_ack_out    <= hit_lock || hit_cfg;
      cmd_error_out  <= hit_none;
      cmd_rdata_out  <= rdata_d;
      soft_reset_out <= soft_reset_req;  // see RULE_01
    end
  end

  // Pin gates and settings, registered so the pins never glitch.
  wire       alert_drive = alert_req_in && alert_en_q;  // see RULE_08
  wire [1:0] phases      = (ps_sel_q == PS_SEL_TWO_PHASE)
                           ? PHASES_TWO : PHASES_ONE;  // see RULE_05

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_out                   <= 1'b0;
      alert_oe_n_out              <= 1'b1;
      power_save_phase_select_out <= CFG_RESET_VALUE[PS_SEL_MSB:PS_SEL_LSB];
      power_save_phases_out       <= PHASES_ONE;
      bus_timeout_enable_out      <= CFG_RESET_VALUE[TIMEOUT_EN_BIT];
      monitor_enable_out          <= 1'b0;
      lock_out                    <= 1'b0;
    end else begin
      fault_out                   <= fault_req_in
                                     && fault_en_q;  // see RULE_07
      alert_oe_n_out              <= !alert_drive;
      power_save_phase_select_out <= ps_sel_q;
      power_save_phases_out       <= phases;
      bus_timeout_enable_out      <= timeout_en_q;
      monitor_enable_out          <= monitor_en_q;  // see RULE_09
      lock_out                    <= lock_q;  // see RULE_04
    end
  end

  // Bus activity is any settled edge on either line.
  logic       pins_changed;

  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .pins_in     ({scl_in, sda_in}),
    .level_out   (),
    .changed_out (pins_changed)
  );

  // The watcher only sees the engine's addressed flag, so a hang while
  // another device is addressed is left to that device.
  bus_timeout #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_bus_timeout (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .enable_in    (timeout_en_q),
    .addressed_in (addressed_in),
    .activity_in  (pins_changed),
    .release_out  (bus_release_out)  // see RULE_06
  );

endmodule

// file: verification/lock_cfg_assertions.sv
/*
  Port checker for the lock and configuration register block.
  Assumes one clock and an asynchronous, active high reset.
*/
module lock_cfg_checker (
  // Watched ports.
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       cmd_valid_in,
  input wire logic       cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic [7:0] cmd_rdata_out,
  input wire logic       addressed_in,
  input wire logic       bus_release_out,
  input wire logic       fault_req_in,
  input wire logic       alert_req_in,
  input wire logic       fault_out,
  input wire logic       alert_oe_n_out,
  input wire logic [1:0] power_save_phase_select_out,
  input wire logic [1:0] power_save_phases_out,
  input wire logic       bus_timeout_enable_out,
  input wire logic       monitor_enable_out,
  input wire logic       lock_out,
  input wire logic       soft_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence wr_seq(c);
    cmd_valid_in && cmd_write_in && cmd_code_in == c;
  endsequence
  // A quiet cycle first, since the lock output lags the lock bit by one.
  sequence reset_wr;
    !$past(cmd_valid_in) && !lock_out ##0 wr_seq(8'hd0) ##0 cmd_wdata_in[1];
  endsequence
  a_soft_reset_pulse: assert property (
    reset_wr |=> soft_reset_out ##1 !soft_reset_out)
    else $error("soft reset pulse wrong");
  a_locked_no_reset: assert property (
    wr_seq(8'hd0) ##0 lock_out |=> !soft_reset_out)
    else $error("soft reset while locked");
  a_lock_sticks: assert property (
    lock_out |=> lock_out)
    else $error("lock cleared");
  a_timeout_frozen: assert property (
    $past(lock_out) && lock_out |-> $stable(bus_timeout_enable_out))
    else $error("timeout enable changed while locked");
  a_phase_map: assert property (
    power_save_phases_out ==
      (power_save_phase_select_out == 2'h1 ? 2'h2 : 2'h1))
    else $error("phase count wrong");
  a_monitor_follows: assert property (
    wr_seq(8'hd1) ##1 !cmd_valid_in |=>
      monitor_enable_out == $past(cmd_wdata_in[0], 2))
    else $error("monitor enable wrong");
  a_fault_gated: assert property (
    !$past(fault_req_in) |-> !fault_out)
    else $error("fault without request");
  a_alert_gated: assert property (
    !$past(alert_req_in) |-> alert_oe_n_out)
    else $error("alert driven without request");
  a_reserved_zero: assert property (
    cmd_valid_in && !cmd_write_in && cmd_code_in[7:1] == 7'h68 |=>
      cmd_rdata_out[5:4] == 2'h0)
    else $error("reserved bits not zero");
  a_release_addressed: assert property (
    bus_release_out |-> $past(addressed_in))
    else $error("release while not addressed");
  a_no_release_off: assert property (
    !bus_timeout_enable_out [*3] |=> !bus_release_out)
    else $error("release while timeout disabled");
endmodule

bind pmbus_lock_and_config_regs lock_cfg_checker u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in),
  .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
  .addressed_in(addressed_in), .bus_release_out(bus_release_out),
  .fault_req_in(fault_req_in), .alert_req_in(alert_req_in),
  .fault_out(fault_out), .alert_oe_n_out(alert_oe_n_out),
  .power_save_phase_select_out(power_save_phase_select_out),
  .power_save_phases_out(power_save_phases_out),
  .bus_timeout_enable_out(bus_timeout_enable_out),
  .monitor_enable_out(monitor_enable_out), .lock_out(lock_out),
  .soft_reset_out(soft_reset_out));

// file: verification/pmbus_host_model.sv
/*
  Behavioural host: one byte command strobes and bus clock activity.
  Assumes pull-ups, so idle bus lines sit high.
*/
module pmbus_host_model (
  // Clock.
  input  wire logic       ref_clk_in,
  // Command port.
  output logic            cmd_valid_out,
  output logic            cmd_write_out,
  output logic      [7:0] cmd_code_out,
  output logic      [7:0] cmd_wdata_out,
  input  wire logic       cmd_ack_in,
  input  wire logic       cmd_error_in,
  input  wire logic [7:0] cmd_rdata_in,
  // Bus pins.
  output logic            scl_out,
  output logic            sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out  = 8'h00;
    cmd_wdata_out = 8'h00;
    scl_out       = 1'b1;
    sda_out       = 1'b1;
  end
  // Unqualified code and data fields are inverted so a stale value is never trusted.
  task automatic xfer(input logic w, input logic [7:0] c, d,
                      output logic [7:0] rd, output logic ak, er);
    @(negedge ref_clk_in);
    cmd_valid_out = 1'b1;
    cmd_write_out = w;
    cmd_code_out  = c;
    cmd_wdata_out = d;
    @(negedge ref_clk_in);
    rd            = cmd_rdata_in;
    ak            = cmd_ack_in;
    er            = cmd_error_in;
    cmd_valid_out = 1'b0;
    cmd_code_out  = ~c;
    cmd_wdata_out = ~d;
  endtask
  // An even count leaves the clock pin at its idle level. Each level is
  // held four cycles, since a pin that flips every cycle never settles in
  // the device's synchroniser and so would not count as activity.
  task automatic wiggle(input int n);
    repeat (n) begin
      repeat (4) @(negedge ref_clk_in);
      scl_out = ~scl_out;
    end
  endtask
endmodule

// file: verification/pmbus_lock_and_config_regs_test.sv
/*
  Self-checking bench for the lock and configuration registers.
  Assumes the host model drives the command port and bus pins.
*/
module pmbus_lock_and_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 20;
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] ph;
  } row_t;
  row_t       rows [5] = '{'{8'h49, 8'h49, 2'h2}, '{8'hf2, 8'hc2, 2'h1},
    '{8'h84, 8'h84, 2'h1}, '{8'h3f, 8'h0f, 2'h1}, '{8'h00, 8'h00, 2'h1}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       addr = 1'b0;
  logic       f_req = 1'b0;
  logic       a_req = 1'b0;
  logic       valid, write, ack, err, scl, sda, rel, fault, alert_n;
  logic       to_en, mon, lock, srst, ak_v, er_v;
  logic [7:0] code, wdata, rdata, rd_v, r0;
  logic [7:0] rel_cnt = 8'h00;
  logic [1:0] psel, phases;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         n;
  always #20 clk = ~clk;
  pmbus_host_model host (
    .ref_clk_in(clk), .cmd_valid_out(valid), .cmd_write_out(write),
    .cmd_code_out(code), .cmd_wdata_out(wdata), .cmd_ack_in(ack),
    .cmd_error_in(err), .cmd_rdata_in(rdata), .scl_out(scl), .sda_out(sda));
  pmbus_lock_and_config_regs #(.TIMEOUT_CYCLES(TO_CYC)) DUT (
    .ref_clk_in(clk), .rst_in(rst), .cmd_valid_in(valid),
    .cmd_write_in(write), .cmd_code_in(code), .cmd_wdata_in(wdata),
    .cmd_ack_out(ack), .cmd_error_out(err), .cmd_rdata_out(rdata),
    .scl_in(scl), .sda_in(sda), .addressed_in(addr),
    .bus_release_out(rel), .fault_req_in(f_req), .alert_req_in(a_req),
    .fault_out(fault), .alert_oe_n_out(alert_n),
    .power_save_phase_select_out(psel), .power_save_phases_out(phases),
    .bus_timeout_enable_out(to_en), .monitor_enable_out(mon),
    .lock_out(lock), .soft_reset_out(srst));
  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] c, d);
    host.xfer(1'b1, c, d, rd_v, ak_v, er_v);
    chk("ack", 8'h01, {7'h0, ak_v});
  endtask
  task automatic rd(input logic [7:0] c, e);
    host.xfer(1'b0, c, 8'h00, rd_v, ak_v, er_v);
    chk("read", e, rd_v);
  endtask
  // The ceiling is several times the length of the planned sequence.
  always @(posedge clk) begin
    cycles++;
    if (rel === 1'b1) rel_cnt <= rel_cnt + 8'h01;
    if (cycles == 3000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'hd1, 8'h07);
    rd(8'hd0, 8'h00);
    chk("mon", 8'h01, {7'h0, mon});
    for (int i = 0; i < 5; i++) begin
      wr(8'hd1, rows[i].wd);
      rd(8'hd1, rows[i].rd);
      chk("phases", {6'h0, rows[i].ph}, {6'h0, phases});
      chk("select", {6'h0, rows[i].rd[7:6]}, {6'h0, psel});
      chk("mon", {7'h0, rows[i].rd[0]}, {7'h0, mon});
    end
    host.xfer(1'b0, 8'h80, 8'h00, rd_v, ak_v, er_v);
    chk("error", 8'h01, {7'h0, er_v & ~ak_v});
    wr(8'hd1, 8'hc8);
    wr(8'hd0, 8'h02);
    chk("srst", 8'h01, {7'h0, srst});
    rd(8'hd1, 8'h07);
    f_req = 1'b1;
    a_req = 1'b1;
    rd(8'hd0, 8'h00);
    chk("fault", 8'h01, {7'h0, fault});
    chk("alert_n", 8'h00, {7'h0, alert_n});
    wr(8'hd1, 8'h00);
    rd(8'hd1, 8'h00);
    chk("fault", 8'h00, {7'h0, fault});
    chk("alert_n", 8'h01, {7'h0, alert_n});
    chk("mon", 8'h00, {7'h0, mon});
    r0 = rel_cnt;
    addr = 1'b1;
    repeat (60) @(negedge clk);
    chk("no release", r0, rel_cnt);
    addr = 1'b0;
    wr(8'hd1, 8'h08);
    @(negedge clk);
    addr = 1'b1;
    n = 0;
    while (rel !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("wait", 8'h01, {7'h0, n > TO_CYC && n < TO_CYC + 9});
    addr = 1'b0;
    @(negedge clk);
    addr = 1'b1;
    r0 = rel_cnt;
    host.wiggle(60);
    chk("busy bus", r0, rel_cnt);
    addr = 1'b0;
    wr(8'hd0, 8'h01);
    wr(8'hd0, 8'h00);
    rd(8'hd0, 8'h01);
    wr(8'hd0, 8'h02);
    chk("srst", 8'h00, {7'h0, srst});
    wr(8'hd1, 8'h40);
    rd(8'hd1, 8'h48);
    chk("lock", 8'h01, {7'h0, lock});
    chk("to_en", 8'h01, {7'h0, to_en});
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(8'hd0, 8'h00);
    rd(8'hd1, 8'h07);
    summarize;
  end
endmodule
